// File: logic/boot_mode_reset_select.sv
// Start-up control: reset release, strap decode, boot load sequencing, fetch pacing, test port.
// Assumes straps are static, the 8-bit boot EPROM answers within one clock, and host or
// link loaders report completion on loader_done_i from the same clock.
`timescale 1ns/1ps

module boot_mode_reset_select
	import boot_select_pkg::*;
#(
	parameter logic [31:0] RESET_VECTOR = RESET_VECTOR_DEF,
	parameter int unsigned BOOT_BYTES   = BOOT_BYTES_DEF,
	parameter int unsigned ADDR_W       = $clog2(BOOT_BYTES_DEF)
) (
	input  wire logic                       ref_clk_i,
	input  wire logic                       nrst_i,
	input  wire logic                       eprom_boot_strap_i,
	input  wire logic                       link_boot_strap_i,
	input  wire logic                       boot_memory_select_i,
	output logic                            boot_memory_select_o,
	output logic                            boot_memory_select_oe_n_o,
	output logic [ADDR_W-1:0]               eprom_addr_o,
	input  wire logic [EPROM_WIDTH-1:0]     eprom_data_i,
	output logic [EPROM_WIDTH-1:0]          boot_byte_o,
	output logic                            boot_byte_valid_o,
	input  wire logic                       loader_done_i,
	output logic [31:0]                     fetch_addr_o,
	output logic                            fetch_valid_o,
	output boot_select_pkg::core_status_t   status_o,
	input  wire logic                       tck_i,
	input  wire logic                       tms_i,
	input  wire logic                       tdi_i,
	input  wire logic                       trst_n_i,
	output logic                            tdo_o
);
	import boot_select_pkg::*;

	logic [2:0]             hold_cnt_q;
	logic                   in_reset;
	logic                   capture;
	strap_t                 strap_s1_q;
	strap_t                 strap_s2_q;
	boot_mode_t             mode_d;
	boot_mode_t             mode_q;
	logic                   reserved_q;
	logic                   loading_q;
	logic                   running_q;
	logic                   load_end;
	logic                   eprom_load;
	logic [ADDR_W-1:0]      addr_q;
	logic [EPROM_WIDTH-1:0] data_s1_q;
	logic [EPROM_WIDTH-1:0] data_s2_q;
	logic [1:0]             vpipe_q;
	logic [31:0]            fetch_q;
	logic                   bms_q;
	logic                   bms_oe_n_q;
	logic                   trst_s1_q;
	logic                   tap_rst_n;
	logic [2:0]             tsync_s1_q;
	logic [2:0]             tsync_s2_q;
	logic                   tck_s3_q;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	// ------------------------------------------------------------
	// Reset release and strap capture
	// ------------------------------------------------------------
	// Asynchronous assertion, counted release so strap synchronisers fill first
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hold_cnt_q <= '0;
		end else if (hold_cnt_q != RST_HOLD_CNT) begin
			hold_cnt_q <= hold_cnt_q + 3'h1;
		end
	end

	assign in_reset = (hold_cnt_q != RST_HOLD_CNT);
	assign capture  = (hold_cnt_q == STRAP_CAPTURE_CNT);

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strap_s1_q <= '0;
			strap_s2_q <= '0;
		end else begin
			strap_s1_q <= '{eprom_boot_strap_i, link_boot_strap_i, boot_memory_select_i};
			strap_s2_q <= strap_s1_q;
		end
	end

	assign mode_d = decode_boot(strap_s2_q);

	// Sampled once; later strap motion is ignored, so a dynamic strap cannot switch modes
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_q     <= MODE_NONE;
			reserved_q <= 1'b0;
		end else if (capture) begin
			mode_q     <= mode_d;
			reserved_q <= is_reserved(strap_s2_q);
		end
	end

	// ------------------------------------------------------------
	// Boot load and run sequencing
	// ------------------------------------------------------------
	assign eprom_load = loading_q && (mode_q == MODE_EPROM);
	assign load_end   = loading_q &&
		(eprom_load ? (addr_q == ADDR_W'(BOOT_BYTES - 1)) : loader_done_i);

	// Reserved straps leave the core halted rather than guess a mode
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			loading_q <= 1'b0;
			running_q <= 1'b0;
		end else if (capture) begin
			loading_q <= (mode_d != MODE_NONE) && !is_reserved(strap_s2_q);
			running_q <= (mode_d == MODE_NONE) && !is_reserved(strap_s2_q);
		end else if (load_end) begin
			loading_q <= 1'b0;
			running_q <= 1'b1;
		end
	end

	// Byte-wide EPROM read: address out, data back through two stages
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr_q    <= '0;
			data_s1_q <= '0;
			data_s2_q <= '0;
			vpipe_q   <= '0;
		end else begin
			if (eprom_load) begin
				addr_q <= addr_q + ADDR_W'(1);
			end
			data_s1_q <= eprom_data_i;
			data_s2_q <= data_s1_q;
			vpipe_q   <= {vpipe_q[0], eprom_load};
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			boot_byte_o       <= '0;
			boot_byte_valid_o <= 1'b0;
		end else begin
			boot_byte_o       <= data_s2_q;
			boot_byte_valid_o <= vpipe_q[1];
		end
	end

	// Select pin: only an output in EPROM mode, active-low chip select while loading
	// Chip select falls with address 0, so the first byte is never read deselected
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bms_q      <= 1'b1;
			bms_oe_n_q <= 1'b1;
		end else if (capture) begin
			bms_q      <= (mode_d != MODE_EPROM);
			bms_oe_n_q <= (mode_d != MODE_EPROM);
		end else if (load_end) begin
			bms_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Instruction fetch pacing
	// ------------------------------------------------------------
	// One fetch per core clock; the rate is only as steady as the clock source
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fetch_q <= RESET_VECTOR;
		end else if (running_q) begin
			fetch_q <= fetch_q + 32'h0000_0001;
		end
	end

	assign eprom_addr_o              = addr_q;
	assign fetch_addr_o              = fetch_q;
	assign fetch_valid_o             = running_q;
	assign boot_memory_select_o      = bms_q;
	assign boot_memory_select_oe_n_o = bms_oe_n_q;
	assign status_o = '{mode_q, reserved_q, loading_q, running_q,
		running_q && (mode_q == MODE_NONE)};

	// ------------------------------------------------------------
	// Test port synchronisation
	// ------------------------------------------------------------
	// Test reset asserts at once and releases through two stages
	always_ff @(posedge ref_clk_i or negedge trst_n_i) begin
		if (!trst_n_i) begin
			trst_s1_q <= 1'b0;
			tap_rst_n <= 1'b0;
		end else begin
			trst_s1_q <= 1'b1;
			tap_rst_n <= trst_s1_q;
		end
	end

	// Test clock is sampled, so it must stay well below a quarter of the core clock
	always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			tsync_s1_q <= '0;
			tsync_s2_q <= '0;
			tck_s3_q   <= 1'b0;
		end else begin
			tsync_s1_q <= {tck_i, tms_i, tdi_i};
			tsync_s2_q <= tsync_s1_q;
			tck_s3_q   <= tsync_s2_q[2];
		end
	end

	test_access_port #(
		.SCAN_LEN ($bits(strap_t))
	) u_tap (
		.clk_i      (ref_clk_i),
		.rst_n_i    (tap_rst_n),
		.tck_rise_i (tsync_s2_q[2] && !tck_s3_q),
		.tck_fall_i (!tsync_s2_q[2] && tck_s3_q),
		.tms_i      (tsync_s2_q[1]),
		.tdi_i      (tsync_s2_q[0]),
		.pins_i     (strap_s2_q),
		.tdo_o      (tdo_o),
		.state_o    ()
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_eprom_chip_select: assert property (capture && mode_d == MODE_EPROM
		|=> !boot_memory_select_oe_n_o && !boot_memory_select_o)
		else $error("EPROM mode did not drive the chip select");
	chk_halt_in_reset: assert property (in_reset |-> !running_q && !loading_q)
		else $error("core left halt before reset release ended");
	chk_host_mode_pick: assert property (capture && strap_s2_q == 3'b001
		|=> mode_q == MODE_HOST && loading_q && boot_memory_select_oe_n_o)
		else $error("host boot not selected");
	chk_link_mode_pick: assert property (capture && strap_s2_q == 3'b011
		|=> mode_q == MODE_LINK && loading_q)
		else $error("link boot not selected");
	chk_no_boot_run: assert property (capture && strap_s2_q == 3'b000
		|=> running_q && status_o.ext_fetch && !loading_q)
		else $error("no-boot mode did not run from external memory");
	chk_fetch_rate: assert property (running_q |=> fetch_q == $past(fetch_q) + 32'h0000_0001)
		else $error("fetch did not advance every clock");
	chk_reset_vector: assert property ($rose(running_q) |-> fetch_q == RESET_VECTOR)
		else $error("execution did not start at the reset vector");
	chk_mode_held: assert property (!capture |=> $stable(mode_q))
		else $error("boot mode changed outside reset");
	chk_eprom_byte_walk: assert property (eprom_load |-> ##3 boot_byte_valid_o)
		else $error("EPROM byte not delivered three cycles after its address");

endmodule : boot_mode_reset_select

// File: logic/boot_select_pkg.sv
// Constants, types and helpers shared by the start-up control block.
// Assumes a single 40 MHz core clock; straps and test pins arrive unsynchronised.
//
// Behaviour
// - EPROM strap high with link strap low boots from EPROM and drives the select pin as chip select.
// - Both straps low with the select pin sampled high selects host processor booting.
// - EPROM strap low, link strap high and select pin high selects link port booting.
// - All three inputs low means no boot load and execution straight from external memory.
// - One instruction is issued per input clock cycle, with no multiplication or division.
// - Processor reset returns all logic except the test port to a known state and execution starts at the reset vector.
// - Asserting the active-low test reset returns the test state machine to reset asynchronously.
// - The test clock is asynchronous to the core clock and mode select steers the test machine.
// - Test data in shifts into the scan path whose serial output appears on test data out.
// - EPROM booting fetches its image over an 8-bit external interface.

package boot_select_pkg;

	// ------------------------------------------------------------
	// Boot modes and carriers
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_NONE  = 2'h0,
		MODE_HOST  = 2'h1,
		MODE_LINK  = 2'h3,
		MODE_EPROM = 2'h2
	} boot_mode_t;

	typedef struct packed {
		logic eprom_boot_strap;
		logic link_boot_strap;
		logic boot_memory_select;
	} strap_t;

	typedef struct packed {
		boot_mode_t mode;
		logic       reserved_combo;
		logic       loading;
		logic       running;
		logic       ext_fetch;
	} core_status_t;

	// ------------------------------------------------------------
	// Reset release timing and widths
	// ------------------------------------------------------------
	localparam logic [2:0]  RST_HOLD_CNT     = 3'h4;
	localparam logic [2:0]  STRAP_CAPTURE_CNT = 3'h3;
	localparam logic [31:0] RESET_VECTOR_DEF = 32'h0000_0000;
	localparam int          BOOT_BYTES_DEF   = 256;
	localparam int          EPROM_WIDTH      = 8;

	// ------------------------------------------------------------
	// Test access port
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		TAP_RESET  = 4'h0,
		TAP_RTI    = 4'h1,
		TAP_SEL_DR = 4'h3,
		TAP_CAP_DR = 4'h2,
		TAP_SH_DR  = 4'h6,
		TAP_EX1_DR = 4'h7,
		TAP_PA_DR  = 4'h5,
		TAP_EX2_DR = 4'h4,
		TAP_UP_DR  = 4'hC,
		TAP_SEL_IR = 4'hD,
		TAP_CAP_IR = 4'hF,
		TAP_SH_IR  = 4'hE,
		TAP_EX1_IR = 4'hA,
		TAP_PA_IR  = 4'hB,
		TAP_EX2_IR = 4'h9,
		TAP_UP_IR  = 4'h8
	} tap_state_t;

	localparam int         IR_WIDTH   = 4;
	localparam logic [3:0] IR_BYPASS  = 4'hF;
	localparam logic [3:0] IR_CAPTURE = 4'h1;

	// Strap decode; reserved combinations fall back to no boot
	function automatic boot_mode_t decode_boot(input strap_t s);
		case ({s.eprom_boot_strap, s.link_boot_strap})
			2'b10:   decode_boot = MODE_EPROM;
			2'b00:   decode_boot = s.boot_memory_select ? MODE_HOST : MODE_NONE;
			2'b01:   decode_boot = s.boot_memory_select ? MODE_LINK : MODE_NONE;
			default: decode_boot = MODE_NONE;
		endcase
	endfunction : decode_boot

	function automatic logic is_reserved(input strap_t s);
		is_reserved = (s.eprom_boot_strap & s.link_boot_strap) |
			(!s.eprom_boot_strap & s.link_boot_strap & !s.boot_memory_select);
	endfunction : is_reserved

endpackage : boot_select_pkg

// File: logic/test_access_port.sv
// Test state machine with instruction register, bypass and boundary scan path.
// Assumes tck edges arrive as one-cycle strobes already synchronised to clk_i.
`timescale 1ns/1ps

module test_access_port
	import boot_select_pkg::*;
#(
	parameter int unsigned SCAN_LEN = 3
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  tck_rise_i,
	input  wire logic                  tck_fall_i,
	input  wire logic                  tms_i,
	input  wire logic                  tdi_i,
	input  wire logic [SCAN_LEN-1:0]   pins_i,
	output logic                       tdo_o,
	output boot_select_pkg::tap_state_t state_o
);
	import boot_select_pkg::*;

	tap_state_t           state_q;
	logic [IR_WIDTH-1:0]  ir_q;
	logic [IR_WIDTH-1:0]  ir_sh_q;
	logic [SCAN_LEN-1:0]  scan_q;
	logic                 byp_q;
	logic                 bypass_sel;

	function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
		case (s)
			TAP_RESET:  tap_next = m ? TAP_RESET  : TAP_RTI;
			TAP_RTI:    tap_next = m ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = m ? TAP_UP_DR  : TAP_PA_DR;
			TAP_PA_DR:  tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
			TAP_EX2_DR: tap_next = m ? TAP_UP_DR  : TAP_SH_DR;
			TAP_UP_DR:  tap_next = m ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_IR: tap_next = m ? TAP_RESET  : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = m ? TAP_UP_IR  : TAP_PA_IR;
			TAP_PA_IR:  tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
			TAP_EX2_IR: tap_next = m ? TAP_UP_IR  : TAP_SH_IR;
			TAP_UP_IR:  tap_next = m ? TAP_SEL_DR : TAP_RTI;
			default:    tap_next = TAP_RESET;
		endcase
	endfunction : tap_next

	assign bypass_sel = (ir_q == IR_BYPASS);
	assign state_o    = state_q;

	// ------------------------------------------------------------
	// State machine
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= TAP_RESET;
		end else if (tck_rise_i) begin
			state_q <= tap_next(state_q, tms_i);
		end
	end

	// ------------------------------------------------------------
	// Instruction register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ir_sh_q <= '0;
			ir_q    <= IR_BYPASS;
		end else if (tck_rise_i) begin
			case (state_q)
				TAP_RESET:  ir_q    <= IR_BYPASS;
				TAP_CAP_IR: ir_sh_q <= IR_CAPTURE;
				TAP_SH_IR:  ir_sh_q <= {tdi_i, ir_sh_q[IR_WIDTH-1:1]};
				TAP_UP_IR:  ir_q    <= ir_sh_q;
				default:    ir_q    <= ir_q;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Data path: bypass bit or boundary scan
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scan_q <= '0;
			byp_q  <= 1'b0;
		end else if (tck_rise_i) begin
			if (state_q == TAP_CAP_DR) begin
				scan_q <= pins_i;
				byp_q  <= 1'b0;
			end else if (state_q == TAP_SH_DR) begin
				if (bypass_sel) begin
					byp_q <= tdi_i;
				end else begin
					scan_q <= {tdi_i, scan_q[SCAN_LEN-1:1]};
				end
			end
		end
	end

	// Output changes on the falling test clock so the far end samples it settled
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tdo_o <= 1'b0;
		end else if (tck_fall_i) begin
			if (state_q == TAP_SH_IR) begin
				tdo_o <= ir_sh_q[0];
			end else if (state_q == TAP_SH_DR) begin
				tdo_o <= bypass_sel ? byp_q : scan_q[0];
			end
		end
	end

	chk_tap_async_reset: assert property (@(posedge clk_i) !rst_n_i |-> state_q == TAP_RESET)
		else $error("test state machine not held in reset");
	chk_tms_steer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		tck_rise_i && state_q == TAP_RTI && tms_i |=> state_q == TAP_SEL_DR)
		else $error("mode select did not leave idle");
	chk_tdo_scan_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		tck_fall_i && state_q == TAP_SH_DR && !bypass_sel |=> tdo_o == $past(scan_q[0]))
		else $error("scan output not presented on test data out");

endmodule : test_access_port

// File: test/board_model.sv
// Board side of the start-up block: strap levels, shared select pin, 8-bit boot EPROM.
// Assumes the bench sets the strap pattern while processor reset is held.
`timescale 1ns/1ps

module board_model
	import boot_select_pkg::*;
#(
	parameter int unsigned ADDR_W = 2
) (
	input  wire boot_select_pkg::strap_t strap_cfg_i,
	input  wire logic                    sel_drive_i,
	input  wire logic                    sel_oe_n_i,
	input  wire logic [ADDR_W-1:0]       eprom_addr_i,
	output logic                         eprom_boot_strap_o,
	output logic                         link_boot_strap_o,
	output logic                         sel_wire_o,
	output logic [EPROM_WIDTH-1:0]       eprom_data_o
);
	// Fixed resistors; the bench moves them under reset to pick a mode, and after capture to test refusal
	assign eprom_boot_strap_o = strap_cfg_i.eprom_boot_strap;
	assign link_boot_strap_o  = strap_cfg_i.link_boot_strap;
	// Pin shows the device drive when enabled, else the strap
	assign sel_wire_o = sel_oe_n_i ? strap_cfg_i.boot_memory_select : sel_drive_i;
	// Undriven pin or chip select high shows the inverse, so stale bytes cannot match
	assign eprom_data_o = (sel_oe_n_i || sel_drive_i) ? ~(8'hC3 + 8'(eprom_addr_i))
		: 8'hC3 + 8'(eprom_addr_i);
endmodule : board_model

// File: test/tb.sv
// Bench for the start-up block: boot modes, fetch pacing, resets and the test port.
// Assumes the board model for straps and EPROM, and a 40 MHz core clock.
`timescale 1ns/1ps

module tb;
	import boot_select_pkg::*;

	localparam logic [31:0] RV = 32'h0000_0100;
	localparam int unsigned NB = 4;

	logic         ref_clk;
	logic         nrst;
	strap_t       strap_cfg;
	logic         e_strap;
	logic         l_strap;
	logic         sel_wire;
	logic         sel_drv;
	logic         sel_oe_n;
	logic [1:0]   eprom_addr;
	logic [7:0]   eprom_data;
	logic [7:0]   boot_byte;
	logic         byte_valid;
	logic         loader_done;
	logic [31:0]  fetch_addr;
	logic         fetch_valid;
	core_status_t status;
	logic         tck;
	logic         tms;
	logic         tdi;
	logic         trst_n;
	logic         tdo;
	int           errors;
	int           n_checks;

	board_model #(.ADDR_W(2)) board_model_inst (
		.strap_cfg_i(strap_cfg), .sel_drive_i(sel_drv), .sel_oe_n_i(sel_oe_n),
		.eprom_addr_i(eprom_addr), .eprom_boot_strap_o(e_strap),
		.link_boot_strap_o(l_strap), .sel_wire_o(sel_wire), .eprom_data_o(eprom_data));

	boot_mode_reset_select #(.RESET_VECTOR(RV), .BOOT_BYTES(NB), .ADDR_W(2))
	boot_mode_reset_select_inst (
		.ref_clk_i(ref_clk), .nrst_i(nrst), .eprom_boot_strap_i(e_strap),
		.link_boot_strap_i(l_strap), .boot_memory_select_i(sel_wire),
		.boot_memory_select_o(sel_drv), .boot_memory_select_oe_n_o(sel_oe_n),
		.eprom_addr_o(eprom_addr), .eprom_data_i(eprom_data), .boot_byte_o(boot_byte),
		.boot_byte_valid_o(byte_valid), .loader_done_i(loader_done),
		.fetch_addr_o(fetch_addr), .fetch_valid_o(fetch_valid), .status_o(status),
		.tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo));

	initial ref_clk = 1'b0;
	always #12.5 ref_clk = ~ref_clk;

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	// Reset with new straps, stop just after the edge where the mode lands
	task automatic start_boot(input strap_t s, input boot_mode_t m, input logic resv);
		@(posedge ref_clk);
		nrst      <= 1'b0;
		strap_cfg <= s;
		repeat (8) @(posedge ref_clk);
		#1;
		check("reset fetch_valid", fetch_valid, 0);
		check("reset fetch_addr", fetch_addr, RV);
		check("reset oe_n", sel_oe_n, 1);
		@(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		check("mode", status.mode, m);
		check("reserved flag", status.reserved_combo, resv);
	endtask : start_boot

	task automatic fetch_run();
		check("running", status.running, 1);
		check("fetch_valid", fetch_valid, 1);
		check("first fetch", fetch_addr, RV);
		repeat (5) @(posedge ref_clk);
		#1;
		check("fetch pace", fetch_addr, RV + 5);
	endtask : fetch_run

	// Moving the straps after capture must not disturb the mode
	task automatic hold_mode(input boot_mode_t m);
		@(posedge ref_clk);
		strap_cfg <= ~strap_cfg;
		repeat (6) @(posedge ref_clk);
		#1;
		check("held mode", status.mode, m);
		check("still running", fetch_valid, 1);
	endtask : hold_mode

	// One test clock per bit, slow against the core clock; tdo read before each rise
	task automatic tap_seq(input logic [15:0] tms_v, input logic [15:0] tdi_v, input int n,
			output logic [15:0] tdo_v);
		tdo_v = '0;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			tms <= tms_v[i];
			tdi <= tdi_v[i];
			repeat (6) @(posedge ref_clk);
			tdo_v[i] = tdo;
			tck <= 1'b1;
			repeat (6) @(posedge ref_clk);
			tck <= 1'b0;
		end
	endtask : tap_seq

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_no_boot();
		start_boot(3'b000, MODE_NONE, 1'b0);
		check("ext_fetch", status.ext_fetch, 1);
		check("no load", status.loading, 0);
		fetch_run();
		hold_mode(MODE_NONE);
		$display("test no_boot done");
	endtask : test_no_boot

	task automatic test_loader_boot();
		strap_t     s [2] = '{3'b001, 3'b011};
		boot_mode_t m [2] = '{MODE_HOST, MODE_LINK};
		for (int k = 0; k < 2; k++) begin
			start_boot(s[k], m[k], 1'b0);
			check("loading", status.loading, 1);
			check("pin is input", sel_oe_n, 1);
			repeat (3) @(posedge ref_clk);
			#1;
			check("wait loader", fetch_valid, 0);
			@(posedge ref_clk);
			loader_done <= 1'b1;
			@(posedge ref_clk);
			loader_done <= 1'b0;
			#1;
			fetch_run();
			check("ext_fetch off", status.ext_fetch, 0);
			hold_mode(m[k]);
		end
		$display("test loader_boot done");
	endtask : test_loader_boot

	task automatic test_eprom_boot();
		int nb;
		int nr;
		nb = 0;
		nr = 0;
		start_boot(3'b100, MODE_EPROM, 1'b0);
		check("pin driven", sel_oe_n, 0);
		check("loading", status.loading, 1);
		check("cs at start", sel_drv, 0);
		check("first address", eprom_addr, 0);
		for (int i = 0; i < 30; i++) begin
			@(posedge ref_clk);
			#1;
			if (byte_valid === 1'b1) begin
				check("boot byte", boot_byte, 8'hC3 + nb);
				nb++;
			end
			if (status.loading === 1'b1)
				check("chip select", sel_drv, 0);
			if (status.running === 1'b1) begin
				if (nr == 0)
					check("first fetch", fetch_addr, RV);
				nr++;
			end
		end
		check("byte count", nb, NB);
		check("fetch pace", fetch_addr, RV + nr - 1);
		check("cs released", sel_drv, 1);
		hold_mode(MODE_EPROM);
		$display("test eprom_boot done");
	endtask : test_eprom_boot

	task automatic test_reserved();
		strap_t s [3] = '{3'b111, 3'b010, 3'b110};
		for (int k = 0; k < 3; k++) begin
			start_boot(s[k], MODE_NONE, 1'b1);
			repeat (4) @(posedge ref_clk);
			#1;
			check("halted", fetch_valid, 0);
			check("no load", status.loading, 0);
			check("pin is input", sel_oe_n, 1);
		end
		$display("test reserved done");
	endtask : test_reserved

	// Straps left at 1-1-0 by the reserved test
	task automatic test_tap_scan();
		logic [15:0] t;
		tap_seq(16'h0306, 16'h0040, 11, t);
		check("ir capture", t[8:5], IR_CAPTURE);
		tap_seq(16'h0061, 16'h0000, 8, t);
		check("scan chain", t[5:3], 3'b110);
		$display("test tap_scan done");
	endtask : test_tap_scan

	// Test reset must drop the scan instruction left by the previous test
	task automatic test_tap_bypass();
		logic [15:0] t;
		@(posedge ref_clk);
		trst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		trst_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		tap_seq(16'h0182, 16'h00D0, 10, t);
		check("bypass", t[7:4], 4'hA);
		$display("test tap_bypass done");
	endtask : test_tap_bypass

	initial begin
		nrst        = 1'b0;
		strap_cfg   = '0;
		loader_done = 1'b0;
		tck         = 1'b0;
		tms         = 1'b1;
		tdi         = 1'b1;
		trst_n      = 1'b0;
		errors      = 0;
		n_checks    = 0;
		repeat (8) @(posedge ref_clk);
		trst_n <= 1'b1;
		test_no_boot();
		test_loader_boot();
		test_eprom_boot();
		test_reserved();
		test_tap_scan();
		test_tap_bypass();
		end_sim();
	end

	// Roughly thirteen times the expected run length
	initial begin
		repeat (8000) @(posedge ref_clk);
		errors++;
		$display("watchdog expired");
		end_sim();
	end
endmodule : tb
